// file: design/ubu_uart.sv
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module ubu_uart
	import ubu_pkg::*;
#(
	parameter int TX_DEPTH = 128,
	parameter int RX_DEPTH = 256
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_ce,
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	output logic o_irq,
	input wire logic i_rxd,
	input wire logic i_cts,
	input wire logic i_dsr,
	input wire logic i_dcd,
	input wire logic i_ri,
	output logic o_txd,
	output logic o_rts,
	output logic o_dtr,
	output logic o_rs485_driver_enable
);
	localparam int TXA = $clog2(TX_DEPTH);
	localparam int RXA = $clog2(RX_DEPTH);

	// ==========================================================
	// Reset release
	logic rst_a, rst_n;
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_a <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_a <= 1'b1;
			rst_n <= rst_a;
		end
	end

	// ==========================================================
	// Registers
	logic [7:0] ctrl;
	logic [16:0] baud;
	logic [1:0] modem_out;
	logic [5:0] irq_stat, irq_mask, irq_set;
	logic [7:0] invert;
	logic wr_ctrl, wr_baud, wr_modem, wr_mask, wr_inv, wr_tx, rd_rx;
	assign wr_ctrl = i_wr && i_addr == ADDR_CTRL;
	assign wr_baud = i_wr && i_addr == ADDR_BAUD;
	assign wr_modem = i_wr && i_addr == ADDR_MODEM;
	assign wr_mask = i_wr && i_addr == ADDR_IRQ_MASK;
	assign wr_inv = i_wr && i_addr == ADDR_INVERT;
	assign wr_tx = i_wr && i_addr == ADDR_TX_DATA;
	assign rd_rx = i_rd && i_addr == ADDR_RX_DATA;

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= CTRL_RESET;
			baud <= BAUD_RESET;
			modem_out <= 2'h0;
			irq_mask <= 6'h00;
			invert <= 8'h00;
		end else if (i_ce) begin
			if (wr_ctrl)
				ctrl <= i_wdata[7:0];
			if (wr_baud) begin
				baud <= i_wdata[16:0];
				if (i_wdata[13:0] == 14'h0001)
					baud[16:14] <= 3'h0;
			end
			if (wr_modem)
				modem_out <= i_wdata[1:0];
			if (wr_mask)
				irq_mask <= i_wdata[5:0];
			if (wr_inv)
				invert <= i_wdata[7:0];
		end
	end

	// Set wins over a same-cycle write-one-to-clear.
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n)
			irq_stat <= 6'h00;
		else if (i_ce)
			irq_stat <= (irq_stat & ~((i_wr && i_addr == ADDR_IRQ_STAT) ?
				i_wdata[5:0] : 6'h00)) | irq_set;
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n)
			o_irq <= 1'b0;
		else if (i_ce)
			o_irq <= |(irq_stat & irq_mask);
	end

	// ==========================================================
	// Pin synchronisers with inversion after the second stage
	// They reset to the idle pin level, so no false start follows reset.
	logic [4:0] pin_s1, pin_s2, pin;
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1 <= 5'h1f;
			pin_s2 <= 5'h1f;
		end else if (i_ce) begin
			pin_s1 <= {i_ri, i_dcd, i_dsr, i_cts, i_rxd};
			pin_s2 <= pin_s1;
		end
	end
	assign pin = pin_s2 ^ invert[4:0];
	logic rxd, cts, dsr;
	assign rxd = pin[0];
	assign cts = !pin[1];
	assign dsr = !pin[2];

	// ==========================================================
	// Fractional 16x baud generator
	// A three-bit phase accumulator adds one extra reference cycle in the
	// proportion frac/8, so the average period is integer plus fraction.
	logic [13:0] div_cnt;
	logic [2:0] frac_acc;
	logic [3:0] frac_sum;
	logic [14:0] div_int;
	logic tick;
	assign div_int = (baud[13:0] == 14'h0000) ? 15'h4000 : {1'b0, baud[13:0]};
	assign frac_sum = {1'b0, frac_acc} + {1'b0, baud[16:14]};
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= 14'h0000;
			frac_acc <= 3'h0;
			tick <= 1'b0;
		end else if (i_ce) begin
			tick <= 1'b0;
			if ({1'b0, div_cnt} + 15'h0001 >= div_int + {14'h0, frac_sum[3]}) begin
				div_cnt <= 14'h0000;
				frac_acc <= frac_sum[2:0];
				tick <= 1'b1;
			end else
				div_cnt <= div_cnt + 14'h0001;
		end
	end

	// ==========================================================
	// Buffers
	logic [7:0] tx_mem [TX_DEPTH];
	logic [7:0] rx_mem [RX_DEPTH];
	logic [TXA:0] tx_wp, tx_rp;
	logic [RXA:0] rx_wp, rx_rp;
	logic tx_full, tx_empty, rx_full, rx_empty, tx_pop, rx_push;
	logic [7:0] rx_byte;
	assign tx_full = tx_wp == {~tx_rp[TXA], tx_rp[TXA-1:0]};
	assign tx_empty = tx_wp == tx_rp;
	assign rx_full = rx_wp == {~rx_rp[RXA], rx_rp[RXA-1:0]};
	assign rx_empty = rx_wp == rx_rp;

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_wp <= '0;
			tx_rp <= '0;
		end else if (i_ce) begin
			if (wr_tx && !tx_full) begin
				tx_mem[tx_wp[TXA-1:0]] <= i_wdata[7:0];
				tx_wp <= tx_wp + 1'b1;
			end
			if (tx_pop)
				tx_rp <= tx_rp + 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_wp <= '0;
			rx_rp <= '0;
		end else if (i_ce) begin
			if (rx_push && !rx_full) begin
				rx_mem[rx_wp[RXA-1:0]] <= rx_byte;
				rx_wp <= rx_wp + 1'b1;
			end
			if (rd_rx && !rx_empty)
				rx_rp <= rx_rp + 1'b1;
		end
	end

	// ==========================================================
	// Read port
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n)
			o_rdata <= 32'h0;
		else if (i_ce) begin
			o_rdata <= 32'h0;
			if (i_rd) begin
				if (i_addr == ADDR_CTRL)
					o_rdata <= {24'h0, ctrl};
				else if (i_addr == ADDR_BAUD)
					o_rdata <= {15'h0, baud};
				else if (i_addr == ADDR_MODEM)
					o_rdata <= {26'h0, pin[4:1], modem_out};
				else if (i_addr == ADDR_STATUS)
					o_rdata <= {28'h0, rx_full, rx_empty, tx_full, tx_empty};
				else if (i_addr == ADDR_IRQ_STAT)
					o_rdata <= {26'h0, irq_stat};
				else if (i_addr == ADDR_IRQ_MASK)
					o_rdata <= {26'h0, irq_mask};
				else if (i_addr == ADDR_RX_DATA && !rx_empty)
					o_rdata <= {24'h0, rx_mem[rx_rp[RXA-1:0]]};
				else if (i_addr == ADDR_INVERT)
					o_rdata <= {24'h0, invert};
			end
		end
	end

	// ==========================================================
	// Flow control
	logic xoff_seen, tx_allowed;
	ubu_flow_t flow;
	assign flow = ubu_flow_t'(ctrl[CTRL_FLOW_LSB +: 2]);
	always_comb begin
		case (flow)
			FLOW_RTS_CTS: tx_allowed = cts;
			FLOW_DTR_DSR: tx_allowed = dsr;
			FLOW_XON_XOFF: tx_allowed = !xoff_seen;
			default: tx_allowed = 1'b1;
		endcase
	end

	// ==========================================================
	// Transmitter
	ubu_ser_t tx_st;
	logic [3:0] tx_os;
	logic [2:0] tx_bit;
	logic [7:0] tx_sh;
	logic tx_par, tx_stop2, tx_line;
	assign tx_pop = tx_st == SER_IDLE && tick && !tx_empty && tx_allowed &&
		!ctrl[CTRL_BREAK];
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_st <= SER_IDLE;
			tx_os <= 4'h0;
			tx_bit <= 3'h0;
			tx_sh <= 8'h00;
			tx_par <= 1'b0;
			tx_stop2 <= 1'b0;
			tx_line <= 1'b1;
		end else if (i_ce && tick) begin
			tx_os <= tx_os + 4'h1;
			case (tx_st)
				SER_IDLE: begin
					tx_line <= 1'b1;
					tx_os <= 4'h0;
					if (tx_pop) begin
						tx_sh <= tx_mem[tx_rp[TXA-1:0]];
						tx_par <= ctrl[CTRL_PAR_ODD];
						tx_line <= 1'b0;
						tx_st <= SER_START;
					end
				end
				SER_START: if (tx_os == OVERSAMPLE_LAST) begin
					tx_st <= SER_DATA;
					tx_bit <= 3'h0;
					tx_line <= tx_sh[0];
				end
				SER_DATA: if (tx_os == OVERSAMPLE_LAST) begin
					tx_par <= tx_par ^ tx_sh[0];
					tx_sh <= {1'b0, tx_sh[7:1]};
					if (tx_bit == (ctrl[CTRL_BITS8] ? 3'h7 : 3'h6)) begin
						tx_st <= ctrl[CTRL_PAR_EN] ? SER_PARITY : SER_STOP;
						tx_line <= ctrl[CTRL_PAR_EN] ? tx_par ^ tx_sh[0] : 1'b1;
						tx_stop2 <= ctrl[CTRL_STOP2];
					end else begin
						tx_bit <= tx_bit + 3'h1;
						tx_line <= tx_sh[1];
					end
				end
				SER_PARITY: if (tx_os == OVERSAMPLE_LAST) begin
					tx_st <= SER_STOP;
					tx_line <= 1'b1;
				end
				SER_STOP: if (tx_os == OVERSAMPLE_LAST) begin
					if (tx_stop2)
						tx_stop2 <= 1'b0;
					else
						tx_st <= SER_IDLE;
				end
				default: tx_st <= SER_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Receiver
	ubu_ser_t rx_st;
	logic [3:0] rx_os;
	logic [2:0] rx_bit;
	logic [7:0] rx_sh;
	logic rx_par, rx_zero;
	logic [5:0] rx_ev;
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_st <= SER_IDLE;
			rx_os <= 4'h0;
			rx_bit <= 3'h0;
			rx_sh <= 8'h00;
			rx_par <= 1'b0;
			rx_zero <= 1'b0;
		end else if (i_ce && tick) begin
			rx_os <= rx_os + 4'h1;
			case (rx_st)
				SER_IDLE: begin
					rx_os <= 4'h0;
					if (!rxd)
						rx_st <= SER_START;
				end
				SER_START: if (rx_os == OVERSAMPLE_MID) begin
					rx_st <= rxd ? SER_IDLE : SER_DATA;
					rx_os <= 4'h0;
					rx_bit <= 3'h0;
					rx_sh <= 8'h00;
					rx_par <= ctrl[CTRL_PAR_ODD];
					rx_zero <= 1'b1;
				end
				SER_DATA: if (rx_os == OVERSAMPLE_LAST) begin
					rx_par <= rx_par ^ rxd;
					rx_zero <= rx_zero & !rxd;
					if (ctrl[CTRL_BITS8])
						rx_sh <= {rxd, rx_sh[7:1]};
					else
						rx_sh <= {1'b0, rxd, rx_sh[6:1]};
					if (rx_bit == (ctrl[CTRL_BITS8] ? 3'h7 : 3'h6))
						rx_st <= ctrl[CTRL_PAR_EN] ? SER_PARITY : SER_STOP;
					else
						rx_bit <= rx_bit + 3'h1;
				end
				SER_PARITY: if (rx_os == OVERSAMPLE_LAST) begin
					rx_par <= rx_par ^ rxd;
					rx_zero <= rx_zero & !rxd;
					rx_st <= SER_STOP;
				end
				SER_STOP: if (rx_os == OVERSAMPLE_LAST)
					rx_st <= rxd ? SER_IDLE : SER_PARITY;
				default: rx_st <= SER_IDLE;
			endcase
			// A break holds the line low; wait in parity-to-stop until idle.
			if (rx_st == SER_PARITY && rx_zero && rx_os == OVERSAMPLE_LAST &&
				!ctrl[CTRL_PAR_EN] && rxd)
				rx_st <= SER_IDLE;
		end
	end

	// Frame completion events, one cycle each.
	always_comb begin
		rx_ev = 6'h00;
		rx_push = 1'b0;
		rx_byte = rx_sh;
		if (i_ce && tick && rx_st == SER_STOP && rx_os == OVERSAMPLE_LAST &&
			!(rx_zero && !rxd && !ctrl[CTRL_PAR_EN])) begin
			if (rx_zero && !rxd)
				rx_ev[IRQ_BREAK] = 1'b1;
			else begin
				rx_push = 1'b1;
				rx_ev[IRQ_RX_DONE] = 1'b1;
				rx_ev[IRQ_FRAME_ERR] = !rxd;
				rx_ev[IRQ_PAR_ERR] = ctrl[CTRL_PAR_EN] && rx_par;
				rx_ev[IRQ_OVERRUN] = rx_full;
			end
		end else if (i_ce && tick && rx_st == SER_STOP &&
			rx_os == OVERSAMPLE_LAST && !rxd)
			rx_ev[IRQ_BREAK] = 1'b1;
	end
	assign irq_set = rx_ev | {4'h0, (i_ce && tick && tx_st == SER_STOP &&
		tx_os == OVERSAMPLE_LAST && !tx_stop2), 1'b0};

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n)
			xoff_seen <= 1'b0;
		else if (i_ce && rx_push && flow == FLOW_XON_XOFF) begin
			if (rx_byte == CHAR_XOFF)
				xoff_seen <= 1'b1;
			else if (rx_byte == CHAR_XON)
				xoff_seen <= 1'b0;
		end
	end

	// ==========================================================
	// Output pins
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_txd <= 1'b1;
			o_rts <= 1'b1;
			o_dtr <= 1'b1;
			o_rs485_driver_enable <= 1'b0;
		end else if (i_ce) begin
			o_txd <= (tx_line && !ctrl[CTRL_BREAK]) ^ invert[5];
			o_rts <= !modem_out[0] ^ invert[6];
			o_dtr <= !modem_out[1] ^ invert[7];
			o_rs485_driver_enable <= ctrl[CTRL_RS485] &&
				tx_st != SER_IDLE;
		end
	end

endmodule // ubu_uart

`default_nettype wire

// file: design/ubu_pkg.sv
package ubu_pkg;

	// ==========================================================
	// Register map
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_BAUD = 4'h1;
	localparam logic [3:0] ADDR_MODEM = 4'h2;
	localparam logic [3:0] ADDR_STATUS = 4'h3;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
	localparam logic [3:0] ADDR_TX_DATA = 4'h6;
	localparam logic [3:0] ADDR_RX_DATA = 4'h7;
	localparam logic [3:0] ADDR_INVERT = 4'h8;

	// ==========================================================
	// Control register fields
	localparam int CTRL_BITS8 = 0;
	localparam int CTRL_PAR_EN = 1;
	localparam int CTRL_PAR_ODD = 2;
	localparam int CTRL_STOP2 = 3;
	localparam int CTRL_BREAK = 4;
	localparam int CTRL_RS485 = 5;
	localparam int CTRL_FLOW_LSB = 6;
	localparam logic [7:0] CTRL_RESET = 8'h01;

	// ==========================================================
	// Baud register: integer in 13:0, fraction in 16:14
	localparam int BAUD_FRAC_LSB = 14;
	localparam logic [16:0] BAUD_RESET = 17'h00138;

	// ==========================================================
	// Interrupt bits
	localparam int IRQ_RX_DONE = 0;
	localparam int IRQ_TX_DONE = 1;
	localparam int IRQ_BREAK = 2;
	localparam int IRQ_FRAME_ERR = 3;
	localparam int IRQ_PAR_ERR = 4;
	localparam int IRQ_OVERRUN = 5;

	// ==========================================================
	// Flow modes and characters
	typedef enum logic [1:0] {
		FLOW_NONE = 2'h0,
		FLOW_RTS_CTS = 2'h1,
		FLOW_DTR_DSR = 2'h2,
		FLOW_XON_XOFF = 2'h3
	} ubu_flow_t;
	localparam logic [7:0] CHAR_XON = 8'h11;
	localparam logic [7:0] CHAR_XOFF = 8'h13;
	localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
	localparam logic [3:0] OVERSAMPLE_MID = 4'h7;

	typedef enum logic [2:0] {
		SER_IDLE = 3'b000,
		SER_START = 3'b001,
		SER_DATA = 3'b011,
		SER_PARITY = 3'b010,
		SER_STOP = 3'b110
	} ubu_ser_t;

endpackage

// file: verif/ubu_uart_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Port checker for the UART block.
module ubu_uart_assertions
	import ubu_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_ce,
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic o_irq,
	input wire logic i_rxd,
	input wire logic i_cts,
	input wire logic i_dsr,
	input wire logic i_dcd,
	input wire logic i_ri,
	input wire logic o_txd,
	input wire logic o_rts,
	input wire logic o_dtr,
	input wire logic o_rs485_driver_enable
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);
	// ========================================
	// Shadow of configuration writes.
	// The p_de_off, p_break_out and p_modem_out checks wait three cycles after a write, to cover the register
	// stage and the registered pin without guessing which comes first.
	logic [7:0] ctrl_q;
	logic [7:0] inv_q;
	logic [5:0] mask_q;
	logic [1:0] mdm_q;
	logic [2:0] since_cfg;
	logic wr_on;
	logic cfg_wr;
	assign wr_on = i_wr && i_ce;
	assign cfg_wr = wr_on && (i_addr == ADDR_CTRL || i_addr == ADDR_MODEM
		|| i_addr == ADDR_INVERT);
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl_q <= CTRL_RESET;
			inv_q <= 8'h00;
			mask_q <= 6'h00;
			mdm_q <= 2'h0;
			since_cfg <= 3'h0;
		end else begin
			if (wr_on && i_addr == ADDR_CTRL) ctrl_q <= i_wdata[7:0];
			if (wr_on && i_addr == ADDR_INVERT) inv_q <= i_wdata[7:0];
			if (wr_on && i_addr == ADDR_IRQ_MASK) mask_q <= i_wdata[5:0];
			if (wr_on && i_addr == ADDR_MODEM) mdm_q <= i_wdata[1:0];
			if (cfg_wr) since_cfg <= 3'h0;
			else if (since_cfg != 3'h7) since_cfg <= since_cfg + 3'h1;
		end
	end
	// ========================================
	// Properties.
	property p_rdata_idle;
		!$past(i_rd) |-> o_rdata == 32'h0;
	endproperty
	property p_irq_masked;
		mask_q == 6'h0 && $past(mask_q) == 6'h0 |-> !o_irq;
	endproperty
	property p_reset_idle;
		$rose(i_reset_n) |-> (o_txd && o_rts && o_dtr
			&& !o_rs485_driver_enable) [*2];
	endproperty
	property p_start_len;
		$fell(o_txd) && !ctrl_q[CTRL_BREAK] && !inv_q[5] |-> !o_txd [*8];
	endproperty
	property p_de_on;
		$fell(o_txd) && ctrl_q[CTRL_RS485] && !ctrl_q[CTRL_BREAK]
			&& !inv_q[5] |-> ##1 o_rs485_driver_enable;
	endproperty
	property p_de_off;
		!ctrl_q[CTRL_RS485] && since_cfg >= 3'h3 |-> !o_rs485_driver_enable;
	endproperty
	property p_break_out;
		ctrl_q[CTRL_BREAK] && since_cfg >= 3'h3 |-> o_txd == inv_q[5];
	endproperty
	property p_modem_out;
		since_cfg >= 3'h3 |-> o_rts == (mdm_q[0] ~^ inv_q[6])
			&& o_dtr == (mdm_q[1] ~^ inv_q[7]);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not zero outside a read");
	a_irq_masked: assert property (p_irq_masked)
		else $error("interrupt high with all masked");
	a_reset_idle: assert property (p_reset_idle)
		else $error("outputs not idle after reset");
	a_start_len: assert property (p_start_len)
		else $error("start bit too short");
	a_de_on: assert property (p_de_on)
		else $error("driver enable low during frame");
	a_de_off: assert property (p_de_off)
		else $error("driver enable high while disabled");
	a_break_out: assert property (p_break_out)
		else $error("break not forced on line");
	a_modem_out: assert property (p_modem_out)
		else $error("modem output level wrong");
	c_frame: cover property ($fell(o_txd));
	c_irq: cover property ($rose(o_irq));
	c_de: cover property ($rose(o_rs485_driver_enable));
endmodule // ubu_uart_assertions
`default_nettype wire

// file: verif/ubu_line_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Remote UART on the far side of the serial line.
// Bit length is in clocks; the bench sets it to match the divisor.
module ubu_line_partner (
	input wire logic i_clk,
	input wire logic i_txd,
	output logic o_rxd
);
	int bit_clks = 32;
	int nbits = 8;
	logic [7:0] got[$];
	logic [7:0] b;
	initial o_rxd = 1'b1;
	// Low start, LSB first, high stop; a low stop is dropped.
	initial forever begin
		@(negedge i_txd);
		repeat (bit_clks / 2) @(posedge i_clk);
		b = 8'h00;
		for (int i = 0; i < nbits; i++) begin
			repeat (bit_clks) @(posedge i_clk);
			b[i] = i_txd;
		end
		repeat (bit_clks) @(posedge i_clk);
		if (i_txd) got.push_back(b);
		else wait (i_txd);
	end
	// Sends one frame, or eleven low bits for a break.
	task automatic send(input logic [7:0] d, input logic brk);
		logic [10:0] f;
		f = brk ? 11'h0 : {2'b11, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(posedge i_clk);
			o_rxd <= f[i];
			repeat (bit_clks - 1) @(posedge i_clk);
		end
		@(posedge i_clk);
		o_rxd <= 1'b1;
	endtask
endmodule // ubu_line_partner
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Bench top: bus master, modem lines and the far-side model.
module tb_top
	import ubu_pkg::*;
;
	logic i_clk, i_reset_n, i_wr, i_rd, i_cts, i_dsr, i_dcd, i_ri, rxd;
	logic o_irq, o_txd, o_rts, o_dtr, o_de;
	logic [3:0] i_addr;
	logic [31:0] i_wdata, o_rdata, rdv;
	logic [7:0] b, inv;
	logic [7:0] exp_q[$];
	logic [13:0] bint[4] = '{14'h2, 14'h2, 14'h3, 14'h1};
	logic [2:0] bfrac[4] = '{3'h0, 3'h4, 3'h1, 3'h7};
	int errors = 0;
	int samples_checked = 0;
	int seed = 17;
	int n, len;
	ubu_uart ubu_uart_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_ce(1'b1), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_rxd(rxd),
		.i_cts(i_cts), .i_dsr(i_dsr), .i_dcd(i_dcd), .i_ri(i_ri),
		.o_txd(o_txd), .o_rts(o_rts), .o_dtr(o_dtr),
		.o_rs485_driver_enable(o_de));
	ubu_line_partner ubu_line_partner_inst (.i_clk(i_clk), .i_txd(o_txd),
		.o_rxd(rxd));
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	// ========================================
	// Expectations and bus tasks.
	function automatic int exp_len(logic [13:0] ni, logic [2:0] fr);
		return (ni == 14'h1) ? 16 : 16 * int'(ni) + 2 * int'(fr);
	endfunction
	function automatic logic [31:0] exp_modem(logic [3:0] p, logic [7:0] iv);
		return {26'h0, p ^ iv[4:1], 2'h0};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		samples_checked++;
		if (got !== want) begin
			errors++;
			$display("mismatch at %0t: got %h want %h", $time, got, want);
		end
	endtask
	task automatic final_report();
		$display("checked %0d, errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic bus_rd(input logic [3:0] a);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 rdv = o_rdata;
	endtask
	// Waits for the interrupt or for all expected bytes on the line.
	task automatic hold(input logic on_irq, input int lim);
		n = 0;
		while (n < lim && (on_irq ? o_irq !== 1'b1 :
			ubu_line_partner_inst.got.size() < exp_q.size())) begin
			@(negedge i_clk);
			n++;
		end
		if (n >= lim) begin
			errors++;
			$display("mismatch at %0t: wait ran out", $time);
			final_report();
		end
	endtask
	task automatic measure();
		n = 0;
		while (o_txd !== 1'b0 && n < 2000) begin
			@(negedge i_clk);
			n++;
		end
		len = 0;
		while (o_txd === 1'b0 && len < 2000) begin
			@(negedge i_clk);
			len++;
		end
	endtask
	task automatic pause(input int m, input logic on);
		if (m == 1) i_cts <= on;
		else if (m == 2) i_dsr <= on;
		else ubu_line_partner_inst.send(on ? CHAR_XOFF : CHAR_XON, 1'b0);
	endtask
	task automatic line_chk();
		hold(1'b0, 4000);
		while (exp_q.size() > 0) begin
			chk(ubu_line_partner_inst.got.pop_front(), exp_q.pop_front());
		end
	endtask
	// ========================================
	// Main sequence.
	initial begin
		{i_reset_n, i_wr, i_rd, i_addr, i_wdata} = '0;
		{i_cts, i_dsr, i_dcd, i_ri} = 4'h3;
		repeat (8) @(posedge i_clk);
		i_reset_n <= 1'b1;
		repeat (3) @(posedge i_clk);
		bus_rd(ADDR_CTRL);
		chk(rdv, {24'h0, CTRL_RESET});
		bus_rd(ADDR_BAUD);
		chk(rdv, {15'h0, BAUD_RESET});
		bus_rd(ADDR_STATUS);
		chk(rdv, 32'h5);
		bus_rd(4'hf);
		chk(rdv, 32'h0);
		$display("test reset values finished");
		for (int k = 0; k < 4; k++) begin
			len = exp_len(bint[k], bfrac[k]);
			ubu_line_partner_inst.bit_clks = len;
			bus_wr(ADDR_BAUD, {15'h0, bfrac[k], bint[k]});
			bus_rd(ADDR_BAUD);
			chk(rdv, {15'h0, bint[k] == 14'h1 ? 3'h0 : bfrac[k],
				bint[k]});
			bus_wr(ADDR_TX_DATA, 32'h1);
			exp_q.push_back(8'h01);
			measure();
			chk(len, exp_len(bint[k], bfrac[k]));
			line_chk();
		end
		ubu_line_partner_inst.bit_clks = 32;
		bus_wr(ADDR_BAUD, 32'h2);
		$display("test baud divisors finished");
		for (int k = 0; k < 6; k++) begin
			b = k == 0 ? 8'h00 : k == 1 ? 8'hff : 8'($random(seed));
			exp_q.push_back(b);
			bus_wr(ADDR_TX_DATA, {24'h0, b});
		end
		line_chk();
		bus_wr(ADDR_CTRL, 32'h20);
		ubu_line_partner_inst.nbits = 7;
		bus_wr(ADDR_TX_DATA, 32'hd5);
		exp_q.push_back(8'h55);
		line_chk();
		ubu_line_partner_inst.nbits = 8;
		bus_wr(ADDR_CTRL, 32'h1);
		$display("test send path finished");
		bus_wr(ADDR_IRQ_MASK, 32'h1);
		for (int k = 0; k < 4; k++) begin
			b = 8'($random(seed));
			ubu_line_partner_inst.send(b, 1'b0);
			hold(1'b1, 1000);
			bus_rd(ADDR_RX_DATA);
			chk(rdv, {24'h0, b});
			bus_wr(ADDR_IRQ_STAT, 32'h1);
			repeat (2) @(negedge i_clk);
			chk({31'h0, o_irq}, 32'h0);
		end
		bus_rd(ADDR_RX_DATA);
		chk(rdv, 32'h0);
		bus_wr(ADDR_IRQ_MASK, 32'h4);
		ubu_line_partner_inst.send(8'h00, 1'b1);
		hold(1'b1, 2000);
		bus_rd(ADDR_IRQ_STAT);
		chk(rdv & 32'h4, 32'h4);
		bus_rd(ADDR_RX_DATA);
		chk(rdv, 32'h0);
		bus_wr(ADDR_IRQ_STAT, 32'h3f);
		bus_wr(ADDR_IRQ_MASK, 32'h0);
		bus_wr(ADDR_CTRL, 32'h11);
		repeat (400) @(negedge i_clk);
		chk({31'h0, o_txd}, 32'h0);
		bus_wr(ADDR_CTRL, 32'h1);
		$display("test receive and break finished");
		for (int k = 0; k < 3; k++) begin
			inv = k == 0 ? 8'h00 : 8'($random(seed)) & 8'hde;
			bus_wr(ADDR_INVERT, {24'h0, inv});
			bus_wr(ADDR_MODEM, 32'($random(seed)) & 32'h3);
			{i_ri, i_dcd, i_dsr, i_cts} <= 4'($random(seed));
			repeat (4) @(posedge i_clk);
			bus_rd(ADDR_MODEM);
			chk(rdv & 32'h3c,
				exp_modem({i_ri, i_dcd, i_dsr, i_cts}, inv));
		end
		bus_wr(ADDR_INVERT, 32'h0);
		{i_cts, i_dsr} <= 2'h0;
		$display("test modem lines finished");
		for (int m = 1; m < 4; m++) begin
			bus_wr(ADDR_CTRL, 32'h1 | (m << 6));
			pause(m, 1'b1);
			bus_wr(ADDR_TX_DATA, 32'h5a);
			repeat (400) @(posedge i_clk);
			chk(ubu_line_partner_inst.got.size(), 32'h0);
			pause(m, 1'b0);
			exp_q.push_back(8'h5a);
			line_chk();
		end
		$display("test flow control finished");
		@(posedge i_clk);
		i_reset_n <= 1'b0;
		@(negedge i_clk);
		chk({28'h0, o_txd, o_rts, o_dtr, o_de}, 32'he);
		@(posedge i_clk);
		i_reset_n <= 1'b1;
		repeat (3) @(posedge i_clk);
		bus_rd(ADDR_STATUS);
		chk(rdv, 32'h5);
		$display("test second reset finished");
		final_report();
	end
endmodule // tb_top
bind ubu_uart ubu_uart_assertions ubu_uart_assertions_inst (
	.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.o_irq(o_irq), .i_rxd(i_rxd), .i_cts(i_cts), .i_dsr(i_dsr),
	.i_dcd(i_dcd), .i_ri(i_ri), .o_txd(o_txd), .o_rts(o_rts),
	.o_dtr(o_dtr), .o_rs485_driver_enable(o_rs485_driver_enable));
`default_nettype wire
